// [hw/phy_vendor_mode_registers.v]
// Vendor mode register bank with its serial management slave.
// Assumes mdc, mdio_in, line energy and strap pins are asynchronous to clk;
// receive status inputs and sw_reset come from logic on clk.
`include "phy_vendor_regs.vh"
`default_nettype none

module phy_vendor_mode_registers #(
  parameter [24:0] ENERGY_TIMEOUT_CYCLES = `ENERGY_TIMEOUT_CYCLES
) (
  input wire clk,
  input wire rst_n,
  input wire sw_reset,
  input wire mdc,
  input wire mdio_in,
  output reg mdio_out,
  output reg mdio_oe,
  input wire line_energy_detect,
  input wire strap_mac_if_select,
  input wire [2:0] strap_op_mode,
  input wire [4:0] strap_port_address,
  input wire speed_100,
  input wire rx_packet_active,
  input wire rx_symbol_invalid,
  input wire rx_polarity_reversed,
  output reg energy_detect_powerdown_en,
  output reg sensitive_squelch_active,
  output reg far_end_echo_active,
  output reg irq_scheme_select,
  output reg force_link_up,
  output reg line_energy_present,
  output reg mac_if_select,
  output reg [2:0] op_mode,
  output reg [4:0] port_address,
  output reg crossover_auto_off,
  output reg manual_pair_swap,
  output reg heartbeat_test_off
);

  localparam S_IDLE = 3'd0;
  localparam S_START = 3'd1;
  localparam S_HDR = 3'd2;
  localparam S_TA = 3'd3;
  localparam S_DATA = 3'd4;

  wire [2:0] pin_sync;
  wire [8:0] strap_sync;
  wire mdc_s;
  wire mdio_s;
  wire energy_s;
  wire mdc_rise;
  wire [1:0] hdr_op;
  wire [4:0] hdr_phy;
  wire [4:0] hdr_reg;
  wire addr_match;

  reg mdc_d_reg;
  reg [2:0] state_reg;
  reg [5:0] ones_reg;
  reg [3:0] bit_cnt_reg;
  reg [11:0] hdr_shift_reg;
  reg [15:0] data_shift_reg;
  reg read_drive_reg;
  reg wr_stb_reg;
  reg [4:0] wr_addr_reg;
  reg [15:0] wr_data_reg;

  reg sensitive_squelch_en_reg;
  reg preamble_skip_reg;
  reg far_end_echo_reg;
  reg ignore_addr_on_write_reg;
  reg [1:0] strap_wait_reg;
  reg strap_done_reg;
  reg [24:0] quiet_cnt_reg;
  reg [15:0] sym_err_cnt_reg;
  reg pkt_counted_reg;
  reg pkt_active_d_reg;
  reg polarity_reg;
  reg [15:0] rd_word;

  sync2 #(
    .WIDTH(3)
  ) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({mdc, mdio_in, line_energy_detect}),
    .sync_out(pin_sync)
  );

  sync2 #(
    .WIDTH(9)
  ) u_strap_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({strap_mac_if_select, strap_op_mode, strap_port_address}),
    .sync_out(strap_sync)
  );

  assign mdc_s = pin_sync[2];
  assign mdio_s = pin_sync[1];
  assign energy_s = pin_sync[0];
  assign mdc_rise = mdc_s & ~mdc_d_reg;
  assign hdr_op = hdr_shift_reg[11:10];
  assign hdr_phy = hdr_shift_reg[9:5];
  assign hdr_reg = hdr_shift_reg[4:0];
  assign addr_match = (hdr_phy == port_address);

  // Read data; unmapped addresses return zero
  always @* begin
    rd_word = 16'h0000;
    case (hdr_reg)
      `REG_SILICON_REVISION: begin
        rd_word[`REV_MSB:`REV_LSB] = `REV_VALUE;
      end
      `REG_MODE_CONTROL_STATUS: begin
        rd_word[`MCS_EDPD_BIT] = energy_detect_powerdown_en;
        rd_word[`MCS_LOWSQ_BIT] = sensitive_squelch_en_reg;
        rd_word[`MCS_PRESKIP_BIT] = preamble_skip_reg;
        rd_word[`MCS_FARECHO_BIT] = far_end_echo_reg;
        rd_word[`MCS_IRQSEL_BIT] = irq_scheme_select;
        rd_word[`MCS_ADDRBP_BIT] = ignore_addr_on_write_reg;
        rd_word[`MCS_FORCELINK_BIT] = force_link_up;
        rd_word[`MCS_ENERGY_BIT] = line_energy_present;
      end
      `REG_SPECIAL_MODES: begin
        rd_word[`SM_MACIF_BIT] = mac_if_select;
        rd_word[`SM_MODE_MSB:`SM_MODE_LSB] = op_mode;
        rd_word[`SM_ADDR_MSB:`SM_ADDR_LSB] = port_address;
      end
      `REG_SYMBOL_ERROR_COUNTER: begin
        rd_word = sym_err_cnt_reg;
      end
      `REG_SPECIAL_CONTROL_IND: begin
        rd_word[`SCI_XOVER_OFF_BIT] = crossover_auto_off;
        rd_word[`SCI_PAIR_SWAP_BIT] = manual_pair_swap;
        rd_word[`SCI_HEARTBEAT_OFF_BIT] = heartbeat_test_off;
        rd_word[`SCI_POLARITY_BIT] = polarity_reg;
      end
      default: begin
        rd_word = 16'h0000;
      end
    endcase
  end

  // Management frame engine, one step per mdc rising edge
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mdc_d_reg <= 1'b0;
      state_reg <= S_IDLE;
      ones_reg <= 6'h00;
      bit_cnt_reg <= 4'h0;
      hdr_shift_reg <= 12'h000;
      data_shift_reg <= 16'h0000;
      read_drive_reg <= 1'b0;
      mdio_out <= 1'b0;
      mdio_oe <= 1'b0;
      wr_stb_reg <= 1'b0;
      wr_addr_reg <= 5'h00;
      wr_data_reg <= 16'h0000;
    end else begin
      mdc_d_reg <= mdc_s;
      wr_stb_reg <= 1'b0;
      if (mdc_rise) begin
        case (state_reg)
          S_IDLE: begin
            if (mdio_s) begin
              if (ones_reg != `MGMT_PREAMBLE_BITS) begin
                ones_reg <= ones_reg + 6'h01;
              end
            end else begin
              if ((ones_reg == `MGMT_PREAMBLE_BITS) || preamble_skip_reg) begin
                state_reg <= S_START;
              end
              ones_reg <= 6'h00;
            end
          end
          S_START: begin
            bit_cnt_reg <= 4'h0;
            state_reg <= mdio_s ? S_HDR : S_IDLE;
          end
          S_HDR: begin
            hdr_shift_reg <= {hdr_shift_reg[10:0], mdio_s};
            if (bit_cnt_reg == `MGMT_HDR_LAST) begin
              bit_cnt_reg <= 4'h0;
              state_reg <= S_TA;
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
          S_TA: begin
            if (bit_cnt_reg == 4'h0) begin
              bit_cnt_reg <= 4'h1;
              data_shift_reg <= rd_word;
              // Reads answer only to our own address
              if ((hdr_op == `MGMT_OP_READ) && addr_match) begin
                read_drive_reg <= 1'b1;
                mdio_oe <= 1'b1;
                mdio_out <= 1'b0;
              end else begin
                read_drive_reg <= 1'b0;
              end
            end else begin
              bit_cnt_reg <= 4'h0;
              state_reg <= S_DATA;
              mdio_out <= read_drive_reg & data_shift_reg[15];
              data_shift_reg <= {data_shift_reg[14:0], 1'b0};
            end
          end
          S_DATA: begin
            if (bit_cnt_reg == `MGMT_DATA_LAST) begin
              state_reg <= S_IDLE;
              mdio_oe <= 1'b0;
              mdio_out <= 1'b0;
              read_drive_reg <= 1'b0;
              wr_addr_reg <= hdr_reg;
              wr_data_reg <= {data_shift_reg[14:0], mdio_s};
              if ((hdr_op == `MGMT_OP_WRITE) && (addr_match || ignore_addr_on_write_reg)) begin
                wr_stb_reg <= 1'b1;
              end
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              mdio_out <= read_drive_reg & data_shift_reg[15];
              data_shift_reg <= {data_shift_reg[14:0], mdio_s};
            end
          end
          default: begin
            state_reg <= S_IDLE;
            mdio_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // Software-resettable controls; software reset wins over a write
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      energy_detect_powerdown_en <= `RST_CTRL_BIT;
      sensitive_squelch_en_reg <= `RST_CTRL_BIT;
      preamble_skip_reg <= `RST_CTRL_BIT;
      far_end_echo_reg <= `RST_CTRL_BIT;
      irq_scheme_select <= `RST_CTRL_BIT;
      ignore_addr_on_write_reg <= `RST_CTRL_BIT;
      force_link_up <= `RST_CTRL_BIT;
      crossover_auto_off <= `RST_CTRL_BIT;
      manual_pair_swap <= `RST_CTRL_BIT;
      heartbeat_test_off <= `RST_CTRL_BIT;
      sensitive_squelch_active <= `RST_CTRL_BIT;
      far_end_echo_active <= `RST_CTRL_BIT;
      polarity_reg <= `RST_CTRL_BIT;
    end else begin
      sensitive_squelch_active <= sensitive_squelch_en_reg & energy_detect_powerdown_en;
      // Isolate is not a term here, so echo survives it
      far_end_echo_active <= far_end_echo_reg & mac_if_select;
      polarity_reg <= rx_polarity_reversed;
      if (sw_reset) begin
        energy_detect_powerdown_en <= `RST_CTRL_BIT;
        sensitive_squelch_en_reg <= `RST_CTRL_BIT;
        preamble_skip_reg <= `RST_CTRL_BIT;
        far_end_echo_reg <= `RST_CTRL_BIT;
        irq_scheme_select <= `RST_CTRL_BIT;
        ignore_addr_on_write_reg <= `RST_CTRL_BIT;
        force_link_up <= `RST_CTRL_BIT;
        crossover_auto_off <= `RST_CTRL_BIT;
        manual_pair_swap <= `RST_CTRL_BIT;
        heartbeat_test_off <= `RST_CTRL_BIT;
      end else if (wr_stb_reg) begin
        if (wr_addr_reg == `REG_MODE_CONTROL_STATUS) begin
          energy_detect_powerdown_en <= wr_data_reg[`MCS_EDPD_BIT];
          sensitive_squelch_en_reg <= wr_data_reg[`MCS_LOWSQ_BIT];
          preamble_skip_reg <= wr_data_reg[`MCS_PRESKIP_BIT];
          far_end_echo_reg <= wr_data_reg[`MCS_FARECHO_BIT];
          irq_scheme_select <= wr_data_reg[`MCS_IRQSEL_BIT];
          ignore_addr_on_write_reg <= wr_data_reg[`MCS_ADDRBP_BIT];
          force_link_up <= wr_data_reg[`MCS_FORCELINK_BIT];
        end
        if (wr_addr_reg == `REG_SPECIAL_CONTROL_IND) begin
          crossover_auto_off <= wr_data_reg[`SCI_XOVER_OFF_BIT];
          manual_pair_swap <= wr_data_reg[`SCI_PAIR_SWAP_BIT];
          heartbeat_test_off <= wr_data_reg[`SCI_HEARTBEAT_OFF_BIT];
        end
      end
    end
  end

  // Strap-loaded modes; software reset leaves them alone
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_wait_reg <= 2'b00;
      strap_done_reg <= 1'b0;
      mac_if_select <= 1'b0;
      op_mode <= 3'b000;
      port_address <= 5'h00;
    end else begin
      if (!strap_done_reg) begin
        // Wait for the synchroniser to fill before capturing straps
        strap_wait_reg <= strap_wait_reg + 2'b01;
        if (strap_wait_reg == 2'b10) begin
          strap_done_reg <= 1'b1;
          mac_if_select <= strap_sync[8];
          op_mode <= strap_sync[7:5];
          port_address <= strap_sync[4:0];
        end
      end else if (wr_stb_reg && (wr_addr_reg == `REG_SPECIAL_MODES)) begin
        mac_if_select <= wr_data_reg[`SM_MACIF_BIT];
        op_mode <= wr_data_reg[`SM_MODE_MSB:`SM_MODE_LSB];
        port_address <= wr_data_reg[`SM_ADDR_MSB:`SM_ADDR_LSB];
      end
    end
  end

  // Line energy status; only hardware reset touches it
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_energy_present <= `RST_ENERGY_BIT;
      quiet_cnt_reg <= 25'h0000000;
    end else begin
      if (energy_s) begin
        quiet_cnt_reg <= 25'h0000000;
        line_energy_present <= 1'b1;
      end else if (quiet_cnt_reg == (ENERGY_TIMEOUT_CYCLES - 25'h0000001)) begin
        line_energy_present <= 1'b0;
      end else begin
        quiet_cnt_reg <= quiet_cnt_reg + 25'h0000001;
      end
    end
  end

  // Symbol error counter; management writes never reach it
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sym_err_cnt_reg <= `RST_SYM_ERR;
      pkt_counted_reg <= 1'b0;
      pkt_active_d_reg <= 1'b0;
    end else begin
      pkt_active_d_reg <= rx_packet_active;
      if (sw_reset) begin
        sym_err_cnt_reg <= `RST_SYM_ERR;
        pkt_counted_reg <= 1'b0;
      end else if (speed_100 && rx_symbol_invalid && !pkt_counted_reg) begin
        sym_err_cnt_reg <= sym_err_cnt_reg + 16'h0001;
        pkt_counted_reg <= 1'b1;
      end else if ((rx_packet_active && !pkt_active_d_reg) ||
                   (!rx_packet_active && !rx_symbol_invalid)) begin
        pkt_counted_reg <= 1'b0;
      end
    end
  end

  // Revision, energy, polarity and counter fields have no write path.

endmodule

`default_nettype wire

// [common/phy_vendor_regs.vh]
// Register offsets, field positions, reset values and timing counts
// for the vendor mode register bank. Included by the design file and the test bench.
`ifndef PHY_VENDOR_REGS_VH
`define PHY_VENDOR_REGS_VH

// Register addresses on the management interface
`define REG_SILICON_REVISION 5'h10
`define REG_MODE_CONTROL_STATUS 5'h11
`define REG_SPECIAL_MODES 5'h12
`define REG_SYMBOL_ERROR_COUNTER 5'h1a
`define REG_SPECIAL_CONTROL_IND 5'h1b

// Silicon revision field
`define REV_LSB 6
`define REV_MSB 9
// Arbitrary neutral revision value
`define REV_VALUE 4'h5

// Mode control/status fields
`define MCS_EDPD_BIT 13
`define MCS_LOWSQ_BIT 11
`define MCS_PRESKIP_BIT 10
`define MCS_FARECHO_BIT 9
`define MCS_IRQSEL_BIT 6
`define MCS_ADDRBP_BIT 3
`define MCS_FORCELINK_BIT 2
`define MCS_ENERGY_BIT 1

// Special modes fields
`define SM_MACIF_BIT 14
`define SM_MODE_LSB 5
`define SM_MODE_MSB 7
`define SM_ADDR_LSB 0
`define SM_ADDR_MSB 4

// Special control/indication fields
`define SCI_XOVER_OFF_BIT 15
`define SCI_PAIR_SWAP_BIT 13
`define SCI_HEARTBEAT_OFF_BIT 11
`define SCI_POLARITY_BIT 4

// Reset values
`define RST_CTRL_BIT 1'b0
`define RST_ENERGY_BIT 1'b1
`define RST_SYM_ERR 16'h0000

// Management frame constants
`define MGMT_PREAMBLE_BITS 6'h20
`define MGMT_OP_READ 2'b10
`define MGMT_OP_WRITE 2'b01
`define MGMT_HDR_LAST 4'hb
`define MGMT_DATA_LAST 4'hf

// Timing
`define CLK_FREQ_KHZ 100000
`define ENERGY_TIMEOUT_MS 256
`define ENERGY_TIMEOUT_CYCLES (`ENERGY_TIMEOUT_MS * `CLK_FREQ_KHZ)

`endif

// [hw/sync2.v]
// Two-flop synchroniser for a bundle of independent level signals.
// Assumes each bit changes slowly relative to clk; no bus coherency.
`default_nettype none

module sync2 #(
  parameter WIDTH = 1
) (
  input wire clk,
  input wire rst_n,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

`default_nettype wire

// [dv/phy_vendor_checker.sv]
// Assertion checker for the vendor mode register bank.
// Assumes one clock domain and the asynchronous active-low reset.
`default_nettype none
module phy_vendor_checker #(
  parameter [24:0] ENERGY_TIMEOUT_CYCLES = 25'h186a000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sw_reset,
  input wire logic line_energy_detect,
  input wire logic energy_detect_powerdown_en,
  input wire logic sensitive_squelch_active,
  input wire logic far_end_echo_active,
  input wire logic irq_scheme_select,
  input wire logic force_link_up,
  input wire logic line_energy_present,
  input wire logic mac_if_select,
  input wire logic [2:0] op_mode,
  input wire logic [4:0] port_address,
  input wire logic crossover_auto_off,
  input wire logic manual_pair_swap,
  input wire logic heartbeat_test_off
);
  logic [31:0] quiet_cnt;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Raw quiet time; sync lag makes the design drop a few cycles later
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      quiet_cnt <= 32'h0;
    else if (line_energy_detect)
      quiet_cnt <= 32'h0;
    else if (quiet_cnt != 32'hffffffff)
      quiet_cnt <= quiet_cnt + 32'h1;
  end
  sequence s_energy_steady;
    line_energy_detect [*3];
  endsequence
  sequence s_controls_clear;
    !energy_detect_powerdown_en && !irq_scheme_select && !force_link_up &&
      !crossover_auto_off && !manual_pair_swap && !heartbeat_test_off;
  endsequence
  sequence s_straps_held;
    $stable(port_address) && $stable(op_mode) && $stable(mac_if_select);
  endsequence
  a_squelch_gated: assert property (sensitive_squelch_active |->
    energy_detect_powerdown_en || $past(energy_detect_powerdown_en))
    else $error("squelch active without power-down enable");
  a_echo_reduced_if: assert property (far_end_echo_active |->
    mac_if_select || $past(mac_if_select))
    else $error("far-end echo without reduced interface");
  a_sw_clears: assert property (sw_reset |-> ##[1:2] s_controls_clear)
    else $error("control bit survived software reset");
  a_sw_squelch: assert property (sw_reset |-> ##[1:3] !sensitive_squelch_active)
    else $error("squelch survived software reset");
  a_sw_straps: assert property (sw_reset |=> s_straps_held)
    else $error("strap field changed by software reset");
  a_sw_energy: assert property (sw_reset |=> $stable(line_energy_present))
    else $error("energy status changed by software reset");
  a_hw_energy: assert property ($rose(rst_n) |-> line_energy_present)
    else $error("energy status not set by hardware reset");
  a_energy_early: assert property ($fell(line_energy_present) |->
    quiet_cnt >= ENERGY_TIMEOUT_CYCLES)
    else $error("energy status fell before timeout");
  a_energy_late: assert property (quiet_cnt > ENERGY_TIMEOUT_CYCLES + 8 |->
    !line_energy_present)
    else $error("energy status held after timeout");
  a_energy_rise: assert property (s_energy_steady |-> ##[0:4] line_energy_present)
    else $error("energy status not raised by line energy");
endmodule

bind phy_vendor_mode_registers phy_vendor_checker #(
  .ENERGY_TIMEOUT_CYCLES(ENERGY_TIMEOUT_CYCLES)) chk (.clk(clk), .rst_n(rst_n),
  .sw_reset(sw_reset), .line_energy_detect(line_energy_detect),
  .energy_detect_powerdown_en(energy_detect_powerdown_en),
  .sensitive_squelch_active(sensitive_squelch_active),
  .far_end_echo_active(far_end_echo_active), .irq_scheme_select(irq_scheme_select),
  .force_link_up(force_link_up), .line_energy_present(line_energy_present),
  .mac_if_select(mac_if_select), .op_mode(op_mode), .port_address(port_address),
  .crossover_auto_off(crossover_auto_off), .manual_pair_swap(manual_pair_swap),
  .heartbeat_test_off(heartbeat_test_off));
`default_nettype wire

// [dv/mgmt_station.sv]
// Station management controller model for the serial management pins.
// Assumes the bench resolves the shared data line with a pull-up.
`default_nettype none
module mgmt_station (
  input wire logic clk,
  input wire logic mdio_w,
  output logic mdc,
  output logic drv,
  output logic drv_en,
  output logic rd_valid,
  output logic [15:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    mdc = 1'b0;
    drv = 1'b1;
    drv_en = 1'b0;
    rd_valid = 1'b0;
    rd_data = 16'h0000;
  end
  // One whole 160 ns link period; data changes only while mdc is low
  task automatic slot(input logic en, input logic val);
    drv_en <= en;
    drv <= val;
    mdc <= 1'b0;
    repeat (8) @(posedge clk);
    rd_data <= {rd_data[14:0], mdio_w};
    mdc <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  task automatic frame(input logic pre, input logic [1:0] op, input logic [4:0] pa,
    input logic [4:0] ra, input logic [15:0] wd);
    logic [31:0] bits;
    bits = {2'b01, op, pa, ra, 2'b10, wd};
    if (pre) begin
      repeat (32) slot(1'b1, 1'b1);
    end
    for (int i = 31; i >= 0; i--) begin
      slot(op != 2'b10 || i > 17, bits[i]);
    end
    // Clock stands still low between frames
    mdc <= 1'b0;
    drv_en <= 1'b0;
    rd_valid <= op == 2'b10;
    @(posedge clk);
    rd_valid <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// [dv/phy_vendor_mode_registers_test.sv]
// Self-checking bench for the vendor mode register bank.
// Assumes the station model and the checker are compiled beforehand.
`include "phy_vendor_regs.vh"
`default_nettype none
module phy_vendor_mode_registers_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [24:0] TMO = 25'h00000c8;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sw_reset = 1'b0;
  logic energy = 1'b1;
  logic spd = 1'b1;
  logic pkt = 1'b0;
  logic bad = 1'b0;
  logic pol = 1'b0;
  logic if_sel;
  logic [2:0] mode;
  logic [4:0] pa;
  logic [4:0] sa;
  logic [15:0] sm;
  logic [31:0] seed = 32'he34306f4;
  logic [15:0] exp_q[$];
  int failures = 0;
  int samples_checked = 0;
  wire logic mdc, drv, drv_en, rd_valid, mdio_w, mdio_out, mdio_oe;
  wire logic [15:0] rd_data;
  wire logic edpd, squelch, echo, irq_sel, flink, present, mac_if, xoff, swap, hb_off;
  wire logic [2:0] op_mode;
  wire logic [4:0] port_address;
  // Pull-up wins when nobody drives
  assign mdio_w = mdio_oe ? mdio_out : (drv_en ? drv : 1'b1);
  always #5 clk = ~clk;
  phy_vendor_mode_registers #(.ENERGY_TIMEOUT_CYCLES(TMO)) uut (.clk(clk), .rst_n(rst_n),
    .sw_reset(sw_reset), .mdc(mdc), .mdio_in(mdio_w), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .line_energy_detect(energy), .strap_mac_if_select(if_sel),
    .strap_op_mode(mode), .strap_port_address(pa), .speed_100(spd),
    .rx_packet_active(pkt), .rx_symbol_invalid(bad), .rx_polarity_reversed(pol),
    .energy_detect_powerdown_en(edpd), .sensitive_squelch_active(squelch),
    .far_end_echo_active(echo), .irq_scheme_select(irq_sel), .force_link_up(flink),
    .line_energy_present(present), .mac_if_select(mac_if), .op_mode(op_mode),
    .port_address(port_address), .crossover_auto_off(xoff), .manual_pair_swap(swap),
    .heartbeat_test_off(hb_off));
  mgmt_station sta (.clk(clk), .mdio_w(mdio_w), .mdc(mdc), .drv(drv), .drv_en(drv_en),
    .rd_valid(rd_valid), .rd_data(rd_data));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    samples_checked++;
    if (seen !== want) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic end_of_test;
    if (failures == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [4:0] r, input logic [15:0] d,
    input logic pre);
    sta.frame(pre, 2'b01, a, r, d);
  endtask
  task automatic rd(input logic [4:0] r, input logic [15:0] want);
    exp_q.push_back(want);
    sta.frame(1'b1, 2'b10, sa, r, 16'h0000);
  endtask
  task automatic traffic(input logic in_pkt, input logic at_100, input int n);
    spd <= at_100;
    pkt <= in_pkt;
    repeat (n) begin
      @(posedge clk);
      bad <= 1'b1;
      @(posedge clk);
      bad <= 1'b0;
    end
    @(posedge clk);
    pkt <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic soft_reset;
    sw_reset <= 1'b1;
    @(posedge clk);
    sw_reset <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      check(rd_data, exp_q.pop_front());
    end
  end
  initial begin
    seed = lfsr(seed);
    {if_sel, mode, pa} = seed[8:0];
    sa = pa;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (12) @(posedge clk);
    check(present, 1'b1);
    check({mac_if, op_mode, port_address}, {if_sel, mode, pa});
    wr(sa, 5'h10, 16'hffff, 1'b1);
    rd(5'h10, {6'h00, `REV_VALUE, 6'h00});
    pol <= seed[9];
    wr(sa, 5'h11, 16'hffff, 1'b1);
    rd(5'h11, 16'h2e4e);
    check({edpd, squelch, irq_sel, flink, echo}, {4'hf, if_sel});
    // Other address, no preamble: accepted only through skip and bypass
    wr(sa ^ 5'h01, 5'h11, 16'h0800, 1'b0);
    check({edpd, squelch}, 2'h0);
    wr(sa ^ 5'h01, 5'h11, 16'h2000, 1'b1);
    wr(sa, 5'h11, 16'h2000, 1'b0);
    rd(5'h11, 16'h0802);
    seed = lfsr(seed);
    sm = seed[15:0] & 16'h40ff;
    wr(sa, 5'h12, seed[15:0], 1'b1);
    sa = seed[4:0];
    rd(5'h12, sm);
    check({mac_if, op_mode, port_address}, {sm[14], sm[7:0]});
    wr(sa, 5'h1b, 16'hffff, 1'b1);
    rd(5'h1b, {11'h540, pol, 4'h0});
    check({xoff, swap, hb_off}, 3'h7);
    traffic(1'b1, 1'b1, 3);
    traffic(1'b0, 1'b1, 2);
    traffic(1'b1, 1'b0, 2);
    wr(sa, 5'h1a, 16'hffff, 1'b1);
    rd(5'h1a, 16'h0003);
    rd(5'h1a, 16'h0003);
    energy <= 1'b0;
    repeat (TMO + 20) @(posedge clk);
    check(present, 1'b0);
    soft_reset();
    check(present, 1'b0);
    rd(5'h11, 16'h0000);
    rd(5'h12, sm);
    rd(5'h1b, {11'h000, pol, 4'h0});
    rd(5'h1a, 16'h0000);
    energy <= 1'b1;
    repeat (8) @(posedge clk);
    check(present, 1'b1);
    end_of_test();
  end
  // Whole sequence needs about 20k cycles; limit of 40k cycles is twice that
  initial begin
    #400us;
    failures++;
    end_of_test();
  end
endmodule
`default_nettype wire
